// ### hw/fcpwm_core.sv
// Four-channel pwm core: configuration state, channels and flags
`timescale 1ns/1ps
`default_nettype none
`include "fcpwm_regs.svh"
module fcpwm_core import fcpwm_pkg::*; #(
    parameter int NUM_CH = `FCPWM_NUM_CH
) (
    // Clock, reset and enable
    input wire logic clock,
    input wire logic reset_n,
    input wire logic ce,
    // Shared write data
    input wire logic [31:0] reg_wdata,
    // Clock generator configuration write
    input wire logic clock_gen_config_wr,
    // Per-channel register write strobes
    input wire logic [NUM_CH-1:0] channel_config_wr,
    input wire logic [NUM_CH-1:0] channel_period_wr,
    input wire logic [NUM_CH-1:0] channel_duty_wr,
    input wire logic [NUM_CH-1:0] channel_update_wr,
    // Enable, mask and status strobes
    input wire logic channel_enable_wr,
    input wire logic channel_disable_wr,
    input wire logic irq_unmask_wr,
    input wire logic irq_mask_set_wr,
    input wire logic irq_status_rd,
    // Read-back of configuration
    output logic [31:0] clock_gen_config_q,
    output logic [NUM_CH-1:0][31:0] channel_config_q,
    output logic [NUM_CH-1:0][`FCPWM_CNT_W-1:0] channel_period_q,
    output logic [NUM_CH-1:0][`FCPWM_CNT_W-1:0] channel_duty_q,
    // Read-back of state
    output logic [NUM_CH-1:0][`FCPWM_CNT_W-1:0] channel_counter_q,
    output logic [NUM_CH-1:0] channel_status_q,
    output logic [NUM_CH-1:0] irq_mask_view_q,
    output logic [NUM_CH-1:0] irq_status_q,
    output logic irq_out,
    // Waveform pins
    output logic [NUM_CH-1:0] channel_wave_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    fcpwm_state_s st_ff;
    fcpwm_state_s nxt_st;
    logic [NUM_CH-1:0] ch_tick;
    logic [NUM_CH-1:0] last_up;
    logic [NUM_CH-1:0] period_end;
    fcpwm_clk_if u_clk_bus ();

    // ------------------------------------------------------------------
    // Clock generator
    // ------------------------------------------------------------------
    assign u_clk_bus.cfg = st_ff.gen;

    fcpwm_clkgen u_clkgen (
        .clock(clock),
        .reset_n(reset_n),
        .ce(ce),
        .clk_bus(u_clk_bus)
    );

    // Output level from one channel's state; disabled shows start level
    function automatic logic fcpwm_level(input fcpwm_ch_s c);
        logic at_start;
        if (!c.en) begin
            at_start = 1'b1;
        end else if (c.cfg.center && c.down) begin
            at_start = (c.cnt <= c.dty);
        end else begin
            at_start = (c.cnt < c.dty);
        end
        return at_start ? c.cfg.start_high : ~c.cfg.start_high;
    endfunction

    // ------------------------------------------------------------------
    // Per-channel clock selection and period end detection
    // ------------------------------------------------------------------
    for (genvar i = 0; i < NUM_CH; i++) begin : g_sel
        // Selects 13 and up are unused and give a stopped counter
        assign ch_tick[i] = (st_ff.ch[i].cfg.sel < `FCPWM_NUM_CLK) ?
            u_clk_bus.tick[st_ff.ch[i].cfg.sel] : 1'b0;
        assign last_up[i] = st_ff.ch[i].cnt >=
            st_ff.ch[i].prd - 16'h0001;
        assign period_end[i] = st_ff.ch[i].en && ch_tick[i] &&
            (st_ff.ch[i].prd == 16'h0000 ||
             (st_ff.ch[i].cfg.center ?
              (st_ff.ch[i].down && st_ff.ch[i].cnt <= 16'h0001) :
              last_up[i]));
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (clock_gen_config_wr) begin
            nxt_st.gen.div_a = reg_wdata[`FCPWM_DIV_A_FACTOR_MSB:`FCPWM_DIV_A_FACTOR_LSB];
            nxt_st.gen.pre_a = reg_wdata[`FCPWM_DIV_A_SOURCE_SELECT_MSB:`FCPWM_DIV_A_SOURCE_SELECT_LSB];
            nxt_st.gen.div_b = reg_wdata[`FCPWM_DIV_B_FACTOR_MSB:`FCPWM_DIV_B_FACTOR_LSB];
            nxt_st.gen.pre_b = reg_wdata[`FCPWM_DIV_B_SOURCE_SELECT_MSB:`FCPWM_DIV_B_SOURCE_SELECT_LSB];
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (channel_config_wr[i]) begin
                nxt_st.ch[i].cfg.sel =
                    reg_wdata[`FCPWM_SEL_MSB:`FCPWM_SEL_LSB];
                nxt_st.ch[i].cfg.center = reg_wdata[`FCPWM_CENTER_BIT];
                nxt_st.ch[i].cfg.upd_duty = reg_wdata[`FCPWM_UPD_DUTY_BIT];
                // A running waveform never flips level mid-period
                if (!st_ff.ch[i].en) begin
                    nxt_st.ch[i].cfg.start_high =
                        reg_wdata[`FCPWM_START_HIGH_BIT];
                end
            end
            // Direct writes to a running channel would glitch, so drop them
            if (channel_period_wr[i] && !st_ff.ch[i].en) begin
                nxt_st.ch[i].prd = reg_wdata[`FCPWM_CNT_W-1:0];
            end
            if (channel_duty_wr[i] && !st_ff.ch[i].en) begin
                nxt_st.ch[i].dty = reg_wdata[`FCPWM_CNT_W-1:0];
            end
            // Counter
            if (st_ff.ch[i].en && ch_tick[i]) begin
                if (st_ff.ch[i].prd == 16'h0000) begin
                    nxt_st.ch[i].cnt = 16'h0000;
                    nxt_st.ch[i].down = 1'b0;
                end else if (!st_ff.ch[i].cfg.center) begin
                    if (last_up[i]) begin
                        nxt_st.ch[i].cnt = 16'h0000;
                    end else begin
                        nxt_st.ch[i].cnt = st_ff.ch[i].cnt + 16'h0001;
                    end
                end else if (!st_ff.ch[i].down) begin
                    nxt_st.ch[i].cnt = st_ff.ch[i].cnt + 16'h0001;
                    if (last_up[i]) begin
                        nxt_st.ch[i].down = 1'b1;
                    end
                end else if (st_ff.ch[i].cnt <= 16'h0001) begin
                    nxt_st.ch[i].cnt = 16'h0000;
                    nxt_st.ch[i].down = 1'b0;
                end else begin
                    nxt_st.ch[i].cnt = st_ff.ch[i].cnt - 16'h0001;
                end
            end
            // Double buffer: move the held value at the period boundary
            if (period_end[i] && st_ff.ch[i].upd_pend) begin
                nxt_st.ch[i].upd_pend = 1'b0;
                if (st_ff.ch[i].cfg.upd_duty) begin
                    nxt_st.ch[i].dty = st_ff.ch[i].upd;
                end else begin
                    nxt_st.ch[i].prd = st_ff.ch[i].upd;
                end
            end
            // A write landing on the boundary waits for the next one
            if (channel_update_wr[i]) begin
                nxt_st.ch[i].upd = reg_wdata[`FCPWM_CNT_W-1:0];
                nxt_st.ch[i].upd_pend = 1'b1;
            end
            // Enable restarts the counter, so a joint write aligns channels
            if (channel_enable_wr && reg_wdata[i] && !st_ff.ch[i].en) begin
                nxt_st.ch[i].en = 1'b1;
                nxt_st.ch[i].cnt = 16'h0000;
                nxt_st.ch[i].down = 1'b0;
            end
            if (channel_disable_wr && reg_wdata[i]) begin
                nxt_st.ch[i].en = 1'b0;
                nxt_st.ch[i].cnt = 16'h0000;
                nxt_st.ch[i].down = 1'b0;
            end
            // Mask: disable wins when both strobes name the channel
            if (irq_unmask_wr && reg_wdata[i]) begin
                nxt_st.mask[i] = 1'b1;
            end
            if (irq_mask_set_wr && reg_wdata[i]) begin
                nxt_st.mask[i] = 1'b0;
            end
            // Flag: a period end in the read cycle survives the clear
            if (irq_status_rd) begin
                nxt_st.flag[i] = 1'b0;
            end
            if (period_end[i]) begin
                nxt_st.flag[i] = 1'b1;
            end
            nxt_st.ch[i].wave = fcpwm_level(nxt_st.ch[i]);
        end
        nxt_st.irq = |(nxt_st.flag & nxt_st.mask);
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_ff <= `FCPWM_RST_STATE;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign clock_gen_config_q = {4'h0, st_ff.gen.pre_b, st_ff.gen.div_b,
        4'h0, st_ff.gen.pre_a, st_ff.gen.div_a};
    assign irq_mask_view_q = st_ff.mask;
    assign irq_status_q = st_ff.flag;
    assign irq_out = st_ff.irq;
    for (genvar i = 0; i < NUM_CH; i++) begin : g_out
        assign channel_config_q[i] = {21'h000000, st_ff.ch[i].cfg.upd_duty,
            st_ff.ch[i].cfg.start_high, st_ff.ch[i].cfg.center, 4'h0,
            st_ff.ch[i].cfg.sel};
        assign channel_period_q[i] = st_ff.ch[i].prd;
        assign channel_duty_q[i] = st_ff.ch[i].dty;
        assign channel_counter_q[i] = st_ff.ch[i].cnt;
        assign channel_status_q[i] = st_ff.ch[i].en;
        assign channel_wave_out[i] = st_ff.ch[i].wave;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_reset_gen: assert property (@(posedge clock)
        !reset_n |=> clock_gen_config_q == 32'h00000000)
        else $error("divider fields not cleared by reset");
    a_irq_follow: assert property (@(posedge clock) disable iff (!reset_n)
        irq_out == |(irq_status_q & irq_mask_view_q))
        else $error("interrupt line disagrees with flags and mask");
    c_irq_raised: cover property (@(posedge clock) disable iff (!reset_n)
        !irq_out ##1 irq_out);
    // Gated clock must leave every register untouched
    a_freeze_hold: assert property (@(posedge clock) disable iff (!reset_n)
        !ce |=> st_ff == $past(st_ff))
        else $error("state moved while clock gated");

    for (genvar i = 0; i < NUM_CH; i++) begin : g_chk
        a_reset_chan: assert property (@(posedge clock)
            !reset_n |=> channel_config_q[i] == 32'h00000000 &&
            !channel_status_q[i])
            else $error("channel config not cleared by reset");
        a_left_wrap: assert property (@(posedge clock) disable iff (!reset_n)
            ce && period_end[i] && !st_ff.ch[i].cfg.center &&
            !channel_disable_wr |=> channel_counter_q[i] == 16'h0000)
            else $error("left aligned counter did not restart");
        a_left_step: assert property (@(posedge clock) disable iff (!reset_n)
            ce && ch_tick[i] && channel_status_q[i] && !period_end[i] &&
            !st_ff.ch[i].cfg.center && !channel_disable_wr
            |=> channel_counter_q[i] == $past(channel_counter_q[i]) + 16'h0001)
            else $error("counter did not advance on its tick");
        a_center_top: assert property (@(posedge clock) disable iff (!reset_n)
            ce && ch_tick[i] && channel_status_q[i] && st_ff.ch[i].cfg.center &&
            !st_ff.ch[i].down && last_up[i] && st_ff.ch[i].prd != 16'h0000 &&
            !channel_disable_wr
            |=> st_ff.ch[i].down && channel_counter_q[i] == $past(st_ff.ch[i].prd))
            else $error("centre counter did not turn at period");
        a_center_end: assert property (@(posedge clock) disable iff (!reset_n)
            ce && period_end[i] && st_ff.ch[i].cfg.center && !channel_disable_wr
            |=> !st_ff.ch[i].down && channel_counter_q[i] == 16'h0000)
            else $error("centre period did not end at zero");
        a_duty_start: assert property (@(posedge clock) disable iff (!reset_n)
            channel_status_q[i] && !st_ff.ch[i].cfg.center &&
            channel_counter_q[i] < channel_duty_q[i]
            |-> channel_wave_out[i] == st_ff.ch[i].cfg.start_high)
            else $error("output not at start level inside duty");
        a_fixed_low: assert property (@(posedge clock) disable iff (!reset_n)
            channel_status_q[i] && channel_duty_q[i] == channel_period_q[i] &&
            channel_period_q[i] != 16'h0000 && !st_ff.ch[i].cfg.start_high
            |-> !channel_wave_out[i])
            else $error("output not fixed low with full duty");
        a_fixed_high: assert property (@(posedge clock) disable iff (!reset_n)
            channel_status_q[i] && channel_duty_q[i] == 16'h0000 &&
            !st_ff.ch[i].cfg.start_high |-> channel_wave_out[i])
            else $error("output not fixed high with zero duty");
        a_off_level: assert property (@(posedge clock) disable iff (!reset_n)
            !channel_status_q[i] |-> channel_wave_out[i] ==
            channel_config_q[i][`FCPWM_START_HIGH_BIT])
            else $error("disabled output not at start level");
        a_pol_locked: assert property (@(posedge clock) disable iff (!reset_n)
            ce && channel_status_q[i] && channel_config_wr[i]
            |=> st_ff.ch[i].cfg.start_high == $past(st_ff.ch[i].cfg.start_high))
            else $error("polarity changed on enabled channel");
        a_update_move: assert property (@(posedge clock) disable iff (!reset_n)
            ce && period_end[i] && st_ff.ch[i].upd_pend && st_ff.ch[i].cfg.upd_duty
            |=> channel_duty_q[i] == $past(st_ff.ch[i].upd))
            else $error("held duty not applied at period end");
        a_enable_sync: assert property (@(posedge clock) disable iff (!reset_n)
            ce && channel_enable_wr && reg_wdata[i] && !channel_disable_wr
            && !channel_status_q[i]
            |=> channel_status_q[i] && channel_counter_q[i] == 16'h0000)
            else $error("enabled channel did not start from zero");
        a_flag_set: assert property (@(posedge clock) disable iff (!reset_n)
            ce && period_end[i] |=> irq_status_q[i])
            else $error("period end did not set flag");
        a_read_clear: assert property (@(posedge clock) disable iff (!reset_n)
            ce && irq_status_rd && !period_end[i] |=> !irq_status_q[i])
            else $error("status read did not clear flag");
        a_unmask: assert property (@(posedge clock) disable iff (!reset_n)
            ce && irq_unmask_wr && reg_wdata[i] && !irq_mask_set_wr
            |=> irq_mask_view_q[i])
            else $error("unmask write did not set mask bit");
        a_mask_set: assert property (@(posedge clock) disable iff (!reset_n)
            ce && irq_mask_set_wr && reg_wdata[i] |=> !irq_mask_view_q[i])
            else $error("mask write did not clear mask bit");
        a_period_keep: assert property (@(posedge clock) disable iff (!reset_n)
            ce && channel_status_q[i] && channel_period_wr[i] && !period_end[i]
            |=> channel_period_q[i] == $past(channel_period_q[i]))
            else $error("period taken on enabled channel");
        a_update_prd: assert property (@(posedge clock) disable iff (!reset_n)
            ce && period_end[i] && st_ff.ch[i].upd_pend &&
            !st_ff.ch[i].cfg.upd_duty
            |=> channel_period_q[i] == $past(st_ff.ch[i].upd))
            else $error("held period not applied at period end");
        c_center_period: cover property (@(posedge clock) disable iff (!reset_n)
            period_end[i] && st_ff.ch[i].cfg.center);
        c_update_done: cover property (@(posedge clock) disable iff (!reset_n)
            period_end[i] && st_ff.ch[i].upd_pend);
    end
endmodule // fcpwm_core
`default_nettype wire

// ### hw/fcpwm_regs.svh
// Constants of the four-channel pwm core
`ifndef FCPWM_REGS_SVH
`define FCPWM_REGS_SVH
// ----------------------------------------------------------------------
// Operation
// - Prescaler counter gives master clock divided by 1 to 1024, eleven taps
// - Two linear dividers each divide one chosen tap by 1 to 255
// - Reset clears both divide factors and tap selects, derived clocks stop
// - At reset or while clock is gated, divided taps stay inactive
// - Four channels, each with clock selector, 16-bit counter, comparator
// - Channel clock select picks the counter clock, resets to zero
// - Left aligned: counter runs up to period value minus one then restarts at zero
// - Centre aligned: counter runs up to period then down to zero
// - Duty gives ticks per period or half-period at start level
// - Polarity picks start level high or low, low after reset
// - Alignment is per channel, left aligned after reset
// - Duty zero or equal to period pins output constant per polarity
// - Polarity write applies at once when disabled, ignored when enabled
// - Update value held until period end, then moved to period or duty
// - Channels enabled in one write start together and run in step
// - Period end raises interrupt if unmasked, held until status read
// - Reading interrupt status clears all end-of-period flags returned
// - Unmask write sets mask bit, mask write clears it, zeros ignored
// - Divide factor 0 stops, 1 passes, 2 to 255 divides
// - Enable write ones enable channels, disable write ones disable them
// ----------------------------------------------------------------------
`define FCPWM_NUM_CH 4
`define FCPWM_NUM_TAP 11
`define FCPWM_NUM_CLK 13
`define FCPWM_CNT_W 16
`define FCPWM_PRESC_W 10
`define FCPWM_DIV_W 8
`define FCPWM_SEL_W 4
`define FCPWM_DIV_A_FACTOR_MSB 7
`define FCPWM_DIV_A_FACTOR_LSB 0
`define FCPWM_DIV_A_SOURCE_SELECT_MSB 11
`define FCPWM_DIV_A_SOURCE_SELECT_LSB 8
`define FCPWM_DIV_B_FACTOR_MSB 23
`define FCPWM_DIV_B_FACTOR_LSB 16
`define FCPWM_DIV_B_SOURCE_SELECT_MSB 27
`define FCPWM_DIV_B_SOURCE_SELECT_LSB 24
`define FCPWM_SEL_MSB 3
`define FCPWM_SEL_LSB 0
`define FCPWM_CENTER_BIT 8
`define FCPWM_START_HIGH_BIT 9
`define FCPWM_UPD_DUTY_BIT 10
`define FCPWM_RST_STATE '0
`endif

// ### hw/fcpwm_pkg.sv
// Types of the four-channel pwm core
`default_nettype none
`include "fcpwm_regs.svh"
package fcpwm_pkg;
    typedef logic [`FCPWM_CNT_W-1:0] fcpwm_cnt_t;
    typedef struct packed {
        logic [`FCPWM_DIV_W-1:0] div_a;
        logic [`FCPWM_SEL_W-1:0] pre_a;
        logic [`FCPWM_DIV_W-1:0] div_b;
        logic [`FCPWM_SEL_W-1:0] pre_b;
    } fcpwm_gencfg_s;
    typedef struct packed {
        logic [`FCPWM_SEL_W-1:0] sel;
        logic center;
        logic start_high;
        logic upd_duty;
    } fcpwm_chcfg_s;
    typedef struct packed {
        fcpwm_chcfg_s cfg;
        fcpwm_cnt_t prd;
        fcpwm_cnt_t dty;
        fcpwm_cnt_t cnt;
        fcpwm_cnt_t upd;
        logic upd_pend;
        logic down;
        logic en;
        logic wave;
    } fcpwm_ch_s;
    typedef struct packed {
        fcpwm_gencfg_s gen;
        fcpwm_ch_s [`FCPWM_NUM_CH-1:0] ch;
        logic [`FCPWM_NUM_CH-1:0] mask;
        logic [`FCPWM_NUM_CH-1:0] flag;
        logic irq;
    } fcpwm_state_s;
    typedef struct packed {
        logic [`FCPWM_PRESC_W-1:0] presc;
        logic [`FCPWM_DIV_W-1:0] cnt_a;
        logic [`FCPWM_DIV_W-1:0] cnt_b;
    } fcpwm_gen_s;
endpackage
`default_nettype wire

// ### hw/fcpwm_clk_if.sv
// Clock generator configuration and tick bundle
`timescale 1ns/1ps
`default_nettype none
`include "fcpwm_regs.svh"
interface fcpwm_clk_if;
    fcpwm_pkg::fcpwm_gencfg_s cfg;
    logic [`FCPWM_NUM_CLK-1:0] tick;
    modport gen (input cfg, output tick);
    modport user (output cfg, input tick);
endinterface
`default_nettype wire

// ### hw/fcpwm_clkgen.sv
// Prescaler and two linear dividers of the pwm core
`timescale 1ns/1ps
`default_nettype none
`include "fcpwm_regs.svh"
module fcpwm_clkgen import fcpwm_pkg::*; (
    // Clock, reset and enable
    input wire logic clock,
    input wire logic reset_n,
    input wire logic ce,
    // Configuration in, ticks out
    fcpwm_clk_if.gen clk_bus
);
    fcpwm_gen_s st_ff;
    fcpwm_gen_s nxt_st;
    logic [`FCPWM_NUM_TAP-1:0] tap;
    logic sel_a;
    logic sel_b;
    logic tick_a;
    logic tick_b;
    // Ticks are one-cycle enables; gating by ce keeps taps dead while frozen
    assign tap[0] = ce;
    for (genvar k = 1; k < `FCPWM_NUM_TAP; k++) begin : g_tap
        assign tap[k] = ce && (&st_ff.presc[k-1:0]);
    end
    assign sel_a = (clk_bus.cfg.pre_a < `FCPWM_NUM_TAP) ?
        tap[clk_bus.cfg.pre_a] : 1'b0;
    assign sel_b = (clk_bus.cfg.pre_b < `FCPWM_NUM_TAP) ?
        tap[clk_bus.cfg.pre_b] : 1'b0;
    assign tick_a = sel_a && (clk_bus.cfg.div_a != 8'h00) &&
        (st_ff.cnt_a >= clk_bus.cfg.div_a - 8'h01);
    assign tick_b = sel_b && (clk_bus.cfg.div_b != 8'h00) &&
        (st_ff.cnt_b >= clk_bus.cfg.div_b - 8'h01);
    assign clk_bus.tick = {tick_b, tick_a, tap};
    always_comb begin
        nxt_st = st_ff;
        nxt_st.presc = st_ff.presc + 10'h001;
        if (clk_bus.cfg.div_a == 8'h00 || tick_a) begin
            nxt_st.cnt_a = 8'h00;
        end else if (sel_a) begin
            nxt_st.cnt_a = st_ff.cnt_a + 8'h01;
        end
        if (clk_bus.cfg.div_b == 8'h00 || tick_b) begin
            nxt_st.cnt_b = 8'h00;
        end else if (sel_b) begin
            nxt_st.cnt_b = st_ff.cnt_b + 8'h01;
        end
    end
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_ff <= `FCPWM_RST_STATE;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end
    a_div_off: assert property (@(posedge clock) disable iff (!reset_n)
        clk_bus.cfg.div_a == 8'h00 |-> !tick_a)
        else $error("derived clock a ticks with factor zero");
    a_div_pass: assert property (@(posedge clock) disable iff (!reset_n)
        clk_bus.cfg.div_a == 8'h01 |-> tick_a == sel_a)
        else $error("factor one does not pass the tap");
    a_tap_half: assert property (@(posedge clock) disable iff (!reset_n)
        ce && tap[1] ##1 ce |-> !tap[1] ##1 (!ce || tap[1]))
        else $error("divide-by-two tap has wrong rate");
    a_gated_dead: assert property (@(posedge clock) disable iff (!reset_n)
        !ce |-> tap[`FCPWM_NUM_TAP-1:1] == '0)
        else $error("divided tap active while clock gated");
    c_tick_a: cover property (@(posedge clock) disable iff (!reset_n) tick_a);
endmodule // fcpwm_clkgen
`default_nettype wire

// ### hw/fcpwm_end.sv
// Closing file of the pwm core sources, holds no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### sim/fcpwm_core_bench.sv
// Self-checking bench of the four-channel pwm core
`timescale 1ns/1ps
`default_nettype none
module fcpwm_core_bench;
logic clock = 1'b0, reset_n = 1'b0, ce = 1'b1;
logic [31:0] wd = '0;
logic [9:0] st = '0;
int mismatches = 0, tests_run = 0, cycles = 0;
logic [31:0] gq;
logic [3:0][31:0] cq;
logic [3:0][15:0] dq, cnt, pq;
logic [3:0] cm = 4'h1;
logic [3:0] stat, mv, isq, wave;
logic irq;
logic [15:0] e [6] = '{16'h0, 16'h1, 16'h2, 16'h1, 16'h0, 16'h1};
always #5 clock = ~clock;
fcpwm_core i_fcpwm_core (.clock(clock), .reset_n(reset_n), .ce(ce),
    .reg_wdata(wd), .clock_gen_config_wr(st[0]),
    .channel_config_wr(cm & {4{st[1]}}),
    .channel_period_wr(cm & {4{st[2]}}),
    .channel_duty_wr(cm & {4{st[3]}}),
    .channel_update_wr(cm & {4{st[4]}}),
    .channel_enable_wr(st[5]), .channel_disable_wr(st[6]),
    .irq_unmask_wr(st[7]), .irq_mask_set_wr(st[8]), .irq_status_rd(st[9]),
    .clock_gen_config_q(gq), .channel_config_q(cq), .channel_period_q(pq),
    .channel_duty_q(dq), .channel_counter_q(cnt), .channel_status_q(stat),
    .irq_mask_view_q(mv), .irq_status_q(isq), .irq_out(irq),
    .channel_wave_out(wave));
// Strobe held one cycle, then readbacks settle by the falling edge
task automatic wr(input int k, input logic [31:0] d);
    @(posedge clock);
    wd <= d;
    st[k] <= 1'b1;
    @(posedge clock);
    st <= '0;
    @(negedge clock);
endtask
task automatic chk(input string n, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
        mismatches++;
        $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
endtask
task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
        $display("Finished cleanly");
    end else begin
        $display("Finished with errors");
    end
    $finish;
endtask
always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
        mismatches++;
        wrap_up;
    end
end
task automatic t_reset;
    @(negedge clock);
    chk("gen_cfg", gq, 0);
    chk("ch_cfg", cq[0], 0);
    chk("wave", {28'h0, wave}, 0);
    wr(0, 32'h0a05_0301);
    chk("gen_cfg", gq, 32'h0a05_0301);
    $display("test reset done");
endtask
task automatic t_left;
    wr(1, 0);
    wr(2, 3);
    wr(3, 1);
    chk("period", {16'h0, pq[0]}, 3);
    wr(5, 1);
    for (int i = 0; i < 6; i++) begin
        chk("count", {16'h0, cnt[0]}, i % 3);
        chk("wave", {31'h0, wave[0]}, i % 3 >= 1);
        if (i == 3) chk("flag", {31'h0, isq[0]}, 1);
        @(negedge clock);
    end
    chk("irq", {31'h0, irq}, 0);
    $display("test left done");
endtask
task automatic t_irq;
    wr(7, 1);
    chk("irq", {31'h0, irq}, 1);
    wr(6, 1);
    chk("status", {28'h0, stat}, 0);
    wr(9, 0);
    chk("flags", {28'h0, isq}, 0);
    chk("irq", {31'h0, irq}, 0);
    wr(8, 1);
    chk("mask", {28'h0, mv}, 0);
    $display("test irq done");
endtask
task automatic t_upd_pol;
    wr(1, 32'h400);
    wr(4, 2);
    wr(5, 1);
    chk("duty", {16'h0, dq[0]}, 1);
    repeat (3) @(negedge clock);
    chk("duty", {16'h0, dq[0]}, 2);
    wr(6, 1);
    wr(1, 32'h200);
    chk("wave", {31'h0, wave[0]}, 1);
    wr(5, 1);
    wr(1, 0);
    chk("ch_cfg", cq[0], 32'h200);
    $display("test update done");
endtask
task automatic t_ctr;
    wr(6, 1);
    wr(1, 32'h100);
    wr(2, 2);
    wr(5, 1);
    for (int i = 0; i < 6; i++) begin
        chk("count", {16'h0, cnt[0]}, {16'h0, e[i]});
        @(negedge clock);
    end
    $display("test centre done");
endtask
// Derived clock a at master clock over two, then stopped by factor zero
task automatic t_derived;
    wr(6, 1);
    wr(0, 32'h0000_0002);
    wr(1, 32'h00b);
    wr(2, 4);
    wr(5, 1);
    for (int i = 0; i < 6; i++) begin
        chk("count", {16'h0, cnt[0]}, i / 2);
        @(negedge clock);
    end
    wr(0, 0);
    repeat (4) @(negedge clock);
    chk("stopped", {16'h0, cnt[0]}, 0);
    $display("test derived done");
endtask
// Two channels started together, then frozen, refused and updated
task automatic t_joint;
    wr(6, 32'hf);
    @(posedge clock);
    cm <= 4'h3;
    wr(1, 0);
    wr(2, 5);
    wr(5, 3);
    repeat (3) @(negedge clock);
    chk("count0", {16'h0, cnt[0]}, 3);
    chk("count1", {16'h0, cnt[1]}, 3);
    @(posedge clock);
    ce <= 1'b0;
    repeat (3) @(negedge clock);
    chk("frozen", {16'h0, cnt[0]}, 4);
    @(posedge clock);
    ce <= 1'b1;
    wr(2, 9);
    chk("period", {16'h0, pq[0]}, 5);
    wr(4, 7);
    repeat (4) @(negedge clock);
    chk("period", {16'h0, pq[0]}, 7);
    $display("test joint done");
endtask
initial begin
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    t_reset;
    t_left;
    t_irq;
    t_upd_pol;
    t_ctr;
    t_derived;
    t_joint;
    wrap_up;
end
endmodule // fcpwm_core_bench
`default_nettype wire
